// ### core/rstwd_top.sv
// Reset combiner, power-up delay, reset pin pulldown and watchdog for the controller.
// Assumes pins arrive asynchronously and the cpu events are on aclk.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
module rstwd_top #(
	parameter int         WD_PERIOD      = 65536,
	parameter int         STARTUP        = rstwd_pkg::STARTUP_CYCLES,
	parameter logic [7:0] ROM_CLEAR_BYTE = 8'hFF
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// pins
	input  wire logic                   reset_pin_in,
	output logic                        reset_pin_out,
	output logic                        reset_pin_oe,
	input  wire logic                   irq_test_level,
	input  wire logic                   selfcheck_strap,
	// build options and cpu side
	input  wire logic                   wd_option,
	input  wire logic                   stop_option,
	input  wire rstwd_pkg::rstwd_cpu_s  cpu,
	output logic                        core_reset,
	output rstwd_pkg::rstwd_mode_e      mode,
	output logic                        stop_active,
	// axi4-lite
	input  wire logic [15:0]            s_awaddr,
	input  wire logic                   s_awvalid,
	output logic                        s_awready,
	input  wire logic [31:0]            s_wdata,
	input  wire logic [3:0]             s_wstrb,
	input  wire logic                   s_wvalid,
	output logic                        s_wready,
	output logic [1:0]                  s_bresp,
	output logic                        s_bvalid,
	input  wire logic                   s_bready,
	input  wire logic [15:0]            s_araddr,
	input  wire logic                   s_arvalid,
	output logic                        s_arready,
	output logic [31:0]                 s_rdata,
	output logic [1:0]                  s_rresp,
	output logic                        s_rvalid,
	input  wire logic                   s_rready
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic [2:0]              pin_sync;
	logic                    pin_low;
	logic [1:0]              ctrl;
	rstwd_pkg::rstwd_state_e state;
	logic [12:0]             startup_cnt;
	logic                    wake_by_reset;
	rstwd_pkg::rstwd_src_s   src;
	logic                    any_src;
	logic                    int_src;
	logic                    wd_timeout;
	logic [31:0]             wd_count;
	logic                    wd_clear;
	logic                    wd_run;
	logic [2:0]              pd_cnt;
	logic                    pin_low_d;
	logic                    own_hold;
	logic [2:0]              irq_sync;
	logic [2:0]              strap_sync;
	logic                    irq_lvl;
	logic                    strap_lvl;
	logic                    wdog_seen;
	logic                    core_reset_d;
	logic                    fetch_ok;
	logic                    aw_held;
	logic                    w_held;
	logic [15:0]             aw_addr;
	logic [31:0]             w_data;
	logic [3:0]              w_strb;
	logic                    wr_go;

	// --------------------------------------------------------------
	// reset pin synchroniser
	// --------------------------------------------------------------
	// three stages; the pin counts only when stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync <= 3'h7;
			pin_low  <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], reset_pin_in};
			if (pin_sync[1] == pin_sync[2])
				pin_low <= ~pin_sync[2]; // [RULE3]
		end
	end

	// mode pins are outside the clock domain too; same agree rule as the reset pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sync   <= 3'h0;
			strap_sync <= 3'h0;
			irq_lvl    <= 1'b0;
			strap_lvl  <= 1'b0;
		end else begin
			irq_sync   <= {irq_sync[1:0], irq_test_level};
			strap_sync <= {strap_sync[1:0], selfcheck_strap};
			if (irq_sync[1] == irq_sync[2])
				irq_lvl <= irq_sync[2];
			if (strap_sync[1] == strap_sync[2])
				strap_lvl <= strap_sync[2];
		end
	end

	// --------------------------------------------------------------
	// reset sources
	// --------------------------------------------------------------
	// legal fetch windows; anything else resets immediately
	assign fetch_ok = (cpu.fetch_addr >= rstwd_pkg::RAM_LO && cpu.fetch_addr <= rstwd_pkg::RAM_HI)
	               || (cpu.fetch_addr >= rstwd_pkg::ROM_LO && cpu.fetch_addr <= rstwd_pkg::ROM_HI);

	always_comb begin
		src.pin      = pin_low; // [RULE3]
		src.pwrup    = (state == rstwd_pkg::RSTWD_ST_PWRUP); // [RULE7]
		src.wdog     = wd_timeout; // [RULE9]
		src.badfetch = cpu.fetch && !fetch_ok && !core_reset; // [RULE19]
		src.badstop  = cpu.stop_exec && !stop_option && !core_reset; // [RULE18] [RULE20]
	end

	assign int_src = src.pwrup | src.wdog | src.badfetch | src.badstop;
	assign any_src = int_src | src.pin; // [RULE1]

	// --------------------------------------------------------------
	// combined reset
	// --------------------------------------------------------------
	// registered OR; stays up while any source or the pin pulldown is on.
	// holding through our own pulldown stretches short pulses to a few cycles
	always_ff @(posedge aclk) begin
		if (!aresetn)
			core_reset <= 1'b1;
		else
			core_reset <= any_src || (pd_cnt != 3'h0); // [RULE2] [RULE8] [RULE23]
	end

	// --------------------------------------------------------------
	// power-up and stop sequencer
	// --------------------------------------------------------------
	// stop holds the watchdog off until pin low or wake irq; wake restarts the 4064-cycle delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state         <= rstwd_pkg::RSTWD_ST_PWRUP;
			startup_cnt   <= 13'h0;
			wake_by_reset <= 1'b0;
		end else begin
			case (state)
				rstwd_pkg::RSTWD_ST_PWRUP: begin
					if (startup_cnt == 13'(STARTUP - 1)) begin
						state       <= rstwd_pkg::RSTWD_ST_RUN; // [RULE7]
						startup_cnt <= 13'h0;
					end else begin
						startup_cnt <= startup_cnt + 13'h1;
					end
				end
				rstwd_pkg::RSTWD_ST_RUN: begin
					if (cpu.stop_exec && stop_option && !core_reset)
						state <= rstwd_pkg::RSTWD_ST_STOP; // [RULE17]
				end
				rstwd_pkg::RSTWD_ST_STOP: begin
					if (pin_low || cpu.stop_wake_irq) begin
						state         <= rstwd_pkg::RSTWD_ST_WAKE;
						wake_by_reset <= pin_low;
						startup_cnt   <= 13'h0;
					end
				end
				rstwd_pkg::RSTWD_ST_WAKE: begin
					if (startup_cnt == 13'(STARTUP - 1)) begin
						state         <= rstwd_pkg::RSTWD_ST_RUN;
						wake_by_reset <= 1'b0;
						startup_cnt   <= 13'h0;
					end else begin
						startup_cnt <= startup_cnt + 13'h1;
					end
				end
				default: begin
					state <= rstwd_pkg::RSTWD_ST_PWRUP;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// reset pin pulldown
	// --------------------------------------------------------------
	// a new falling pin edge or any internal source reloads four cycles;
	// the edge is ignored while the count runs or the pin is still held by our own pulldown
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_cnt    <= 3'(rstwd_pkg::PULLDOWN_CYCLES);
			pin_low_d <= 1'b0;
		end else begin
			pin_low_d <= pin_low;
			if (int_src)
				pd_cnt <= 3'(rstwd_pkg::PULLDOWN_CYCLES); // [RULE5]
			else if (pin_low && !pin_low_d && pd_cnt == 3'h0 && !own_hold)
				pd_cnt <= 3'(rstwd_pkg::PULLDOWN_CYCLES); // [RULE6]
			else if (pd_cnt != 3'h0)
				pd_cnt <= pd_cnt - 3'h1;
		end
	end

	// our own pulldown echoes back through the pin synchroniser; without this
	// the echo would retrigger the pulldown forever and re-sample the mode.
	// limitation: an outside hold overlapping our pulldown is not seen as one
	always_ff @(posedge aclk) begin
		if (!aresetn)
			own_hold <= 1'b1;
		else if (reset_pin_oe)
			own_hold <= 1'b1;
		else if (!pin_low)
			own_hold <= 1'b0;
	end

	// open drain: drive low only, enable marks the drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_pin_out <= 1'b0;
			reset_pin_oe  <= 1'b1;
		end else begin
			reset_pin_out <= 1'b0;
			reset_pin_oe  <= int_src || (pd_cnt != 3'h0); // [RULE5] [RULE6]
		end
	end

	// --------------------------------------------------------------
	// operating mode
	// --------------------------------------------------------------
	// only pin or watchdog reset endings re-sample the mode pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset_d <= 1'b1;
			wdog_seen    <= 1'b0;
			mode         <= rstwd_pkg::RSTWD_MODE_SINGLE;
		end else begin
			core_reset_d <= core_reset;
			if (src.wdog || (src.pin && !own_hold))
				wdog_seen <= 1'b1;
			else if (core_reset_d && !core_reset)
				wdog_seen <= 1'b0;
			if (core_reset_d && !core_reset && (wdog_seen || pin_low_d)) begin
				if (irq_lvl && strap_lvl)
					mode <= rstwd_pkg::RSTWD_MODE_CHECK; // [RULE4]
				else
					mode <= rstwd_pkg::RSTWD_MODE_SINGLE; // [RULE21]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			stop_active <= 1'b0;
		else
			stop_active <= (state == rstwd_pkg::RSTWD_ST_STOP);
	end

	// --------------------------------------------------------------
	// watchdog
	// --------------------------------------------------------------
	// off in self-check mode, off when the build option or control bit clears it
	assign wd_run = wd_option && ctrl[rstwd_pkg::CTRL_WD_EN_BIT]
	             && mode == rstwd_pkg::RSTWD_MODE_SINGLE
	             && state != rstwd_pkg::RSTWD_ST_STOP; // [RULE10] [RULE17]
	assign wd_clear = (wr_go && aw_addr == rstwd_pkg::WATCHDOG_CLEAR_ADDR && w_strb[0]
	                  && !w_data[rstwd_pkg::CLEAR_BIT]) || core_reset; // [RULE11]

	rstwd_watchdog #(
		.PERIOD    (WD_PERIOD)
	) u_wd (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.enable    (wd_run),
		.clear     (wd_clear),
		.hold_zero ((cpu.stop_exec && stop_option)
		            || (state == rstwd_pkg::RSTWD_ST_WAKE && wake_by_reset)), // [RULE14] [RULE15]
		.timeout   (wd_timeout),
		.count     (wd_count)
	);

	// --------------------------------------------------------------
	// axi4-lite write
	// --------------------------------------------------------------
	// address and data taken in either order; response after both
	assign wr_go = aw_held && w_held && !s_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 16'h0;
			w_data    <= 32'h0;
			w_strb    <= 4'h0;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= rstwd_pkg::RESP_OKAY;
		end else begin
			s_awready <= !aw_held && !s_awready && !s_bvalid;
			s_wready  <= !w_held && !s_wready && !s_bvalid;
			if (s_awvalid && s_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			if (wr_go) begin
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp  <= (aw_addr == rstwd_pkg::WATCHDOG_CLEAR_ADDR
				          || aw_addr == rstwd_pkg::CTRL_ADDR) ? rstwd_pkg::RESP_OKAY
				                                            : rstwd_pkg::RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// control register: watchdog enable bit 0; stop enable bit 1 is stored and read back but nothing uses it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl <= rstwd_pkg::CTRL_RESET;
		else if (wr_go && aw_addr == rstwd_pkg::CTRL_ADDR && w_strb[0])
			ctrl <= w_data[1:0];
	end

	// --------------------------------------------------------------
	// axi4-lite read
	// --------------------------------------------------------------
	// clear location reads the stored program byte, never watchdog state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0;
			s_rresp   <= rstwd_pkg::RESP_OKAY;
		end else begin
			s_arready <= !s_arready && !s_rvalid;
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp  <= rstwd_pkg::RESP_OKAY;
				case (s_araddr)
					rstwd_pkg::WATCHDOG_CLEAR_ADDR: s_rdata <= {24'h0, ROM_CLEAR_BYTE}; // [RULE12]
					rstwd_pkg::CTRL_ADDR:           s_rdata <= {30'h0, ctrl};
					rstwd_pkg::STATUS_ADDR:         s_rdata <= {22'h0, state, mode, stop_active,
					                                            core_reset, reset_pin_oe, pin_low};
					default: begin
						s_rdata <= 32'h0;
						s_rresp <= rstwd_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

endmodule : rstwd_top

// ### core/rstwd_pkg.sv
// Constants, register map and carrier types for the reset and watchdog control block.
// Assumes a single 25 MHz clock and an AXI4-Lite register port.
// How it works
// [RULE1] five sources (pin, power-up, watchdog, bad fetch, disabled STOP) make one reset
// [RULE2] every peripheral is reset while the combined internal reset is active
// [RULE3] active-low reset pin held low keeps the internal reset asserted
// [RULE4] mode re-sampled only when a pin reset or watchdog reset ends
// [RULE5] internal sources pull the pin low for their length or at least four cycles
// [RULE6] pin-only reset turns our pulldown on for just four cycles
// [RULE7] after power-up, hold reset 4064 cycles for oscillator stabilization
// [RULE8] when power-up delay ends, reset stays until all other sources end
// [RULE9] watchdog times out unless cleared in its period, resetting the device
// [RULE10] watchdog build enable; forced off in test and self-check modes
// [RULE11] writing zero to bit 0 of the clear location restarts the watchdog
// [RULE12] reads of the clear location return program memory contents
// [RULE13] watchdog keeps counting in wait mode
// [RULE14] entering stop mode zeroes the watchdog counter
// [RULE15] reset exit from stop holds watchdog at zero through the 4064-cycle delay
// [RULE16] interrupt exit from stop lets watchdog count through the startup delay
// [RULE17] STOP with watchdog enabled halts the clock so no timeout occurs
// [RULE18] STOP while STOP option disabled is an internal reset source
// [RULE19] fetch outside RAM 0x0080-0x01FF and ROM 0x0F00-0x1FFF resets at once
// [RULE20] disabled STOP resets the chip instead of entering stop mode
// [RULE21] single-chip mode chosen at reset pin rise when interrupt pin is normal
// [RULE22] watchdog period is a parameter counted in processor clocks
// [RULE23] internal reset is the OR of sources, registered on the processor clock

package rstwd_pkg;

	// --------------------------------------------------------------
	// register map (byte addresses on the register port)
	// --------------------------------------------------------------
	localparam logic [15:0] WATCHDOG_CLEAR_ADDR = 16'h1FF0;
	localparam logic [15:0] CTRL_ADDR           = 16'h0000;
	localparam logic [15:0] STATUS_ADDR         = 16'h0004;
	localparam int          CLEAR_BIT           = 0;
	localparam int          CTRL_WD_EN_BIT      = 0;
	localparam int          CTRL_STOP_EN_BIT    = 1;
	localparam logic [1:0]  CTRL_RESET          = 2'h3;
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_SLVERR         = 2'h2;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int          CLK_HZ              = 25_000_000;
	localparam int          STARTUP_CYCLES      = 4064;
	localparam int          PULLDOWN_CYCLES     = 4;
	localparam int          PIN_SYNC_STAGES     = 3;

	// --------------------------------------------------------------
	// legal fetch windows
	// --------------------------------------------------------------
	localparam logic [15:0] RAM_LO              = 16'h0080;
	localparam logic [15:0] RAM_HI              = 16'h01FF;
	localparam logic [15:0] ROM_LO              = 16'h0F00;
	localparam logic [15:0] ROM_HI              = 16'h1FFF;

	// operating modes latched at reset end
	typedef enum logic [1:0] {
		RSTWD_MODE_SINGLE = 2'h1,
		RSTWD_MODE_CHECK  = 2'h2
	} rstwd_mode_e;

	// startup sequencer states
	typedef enum logic [3:0] {
		RSTWD_ST_PWRUP = 4'h1,
		RSTWD_ST_RUN   = 4'h2,
		RSTWD_ST_STOP  = 4'h4,
		RSTWD_ST_WAKE  = 4'h8
	} rstwd_state_e;

	// cpu side events
	typedef struct packed {
		logic        fetch;
		logic [15:0] fetch_addr;
		logic        stop_exec;
		logic        wait_mode;
		logic        stop_wake_irq;
	} rstwd_cpu_s;

	// reset source vector
	typedef struct packed {
		logic pin;
		logic pwrup;
		logic wdog;
		logic badfetch;
		logic badstop;
	} rstwd_src_s;

endpackage : rstwd_pkg

// ### core/rstwd_watchdog.sv
// Watchdog counter with clear, hold and timeout pulse.
// Assumes a single clock; the parent decides when counting is allowed.
`timescale 1ns/100ps
module rstwd_watchdog #(
	parameter int PERIOD = 65536
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic enable,
	input  wire logic clear,
	input  wire logic hold_zero,
	output logic      timeout,
	output logic [31:0] count
);

	// --------------------------------------------------------------
	// counter
	// --------------------------------------------------------------
	// clear and hold win over counting; timeout pulses once then restarts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count   <= 32'h0;
			timeout <= 1'b0;
		end else if (clear || hold_zero || !enable) begin
			count   <= 32'h0; // [RULE11] [RULE14] [RULE15]
			timeout <= 1'b0;
		end else if (count == 32'(PERIOD - 1)) begin
			count   <= 32'h0;
			timeout <= 1'b1; // [RULE9] [RULE22]
		end else begin
			count   <= count + 32'h1; // [RULE13] [RULE16]
			timeout <= 1'b0;
		end
	end

endmodule : rstwd_watchdog

// ### dv/rstwd_top_properties.sv
// Checker for the reset and watchdog block, bound to its top module.
// Assumes the package is compiled first and a single aclk domain.
`timescale 1ns/100ps
module rstwd_top_properties #(
	parameter int         STARTUP        = 4064,
	parameter logic [7:0] ROM_CLEAR_BYTE = 8'hFF
) (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   reset_pin_in,
	input wire logic                   reset_pin_out,
	input wire logic                   reset_pin_oe,
	input wire logic                   stop_option,
	input wire rstwd_pkg::rstwd_cpu_s  cpu,
	input wire logic                   core_reset,
	input wire rstwd_pkg::rstwd_mode_e mode,
	input wire logic                   stop_active,
	input wire logic [15:0]            s_araddr,
	input wire logic                   s_arvalid,
	input wire logic                   s_arready,
	input wire logic [31:0]            s_rdata,
	input wire logic                   s_rvalid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	// held-reset cycles since release; saturates so later resets cannot wrap it
	int   up_cnt;
	logic bad_addr;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			up_cnt <= 0;
		else if (core_reset && up_cnt < STARTUP + 8)
			up_cnt <= up_cnt + 1;
	end
	// fetch outside both legal windows
	assign bad_addr = !((cpu.fetch_addr >= rstwd_pkg::RAM_LO && cpu.fetch_addr <= rstwd_pkg::RAM_HI)
		|| (cpu.fetch_addr >= rstwd_pkg::ROM_LO && cpu.fetch_addr <= rstwd_pkg::ROM_HI));

	sequence bad_fetch_s;
		cpu.fetch && bad_addr && !core_reset;
	endsequence
	sequence pin_held_s;
		!reset_pin_in [*6];
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_pin_value: assert property (reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	chk_pd_min: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*4])
		else $error("pulldown shorter than four cycles");
	chk_pin_reset: assert property (pin_held_s |-> core_reset)
		else $error("pin low without internal reset");
	chk_fetch_reset: assert property (bad_fetch_s |-> ##[1:4] core_reset)
		else $error("bad fetch did not reset");
	chk_fetch_pd: assert property (bad_fetch_s |-> ##[1:5] reset_pin_oe)
		else $error("bad fetch did not pull pin");
	chk_stop_reset: assert property (cpu.stop_exec && !stop_option && !core_reset
		|-> ##[1:4] core_reset)
		else $error("disabled stop did not reset");
	chk_stop_enter: assert property (cpu.stop_exec && stop_option && !core_reset
		|-> ##[1:4] stop_active)
		else $error("stop not entered");
	chk_pwrup_hold: assert property ($fell(core_reset) |-> up_cnt >= STARTUP)
		else $error("reset released before startup delay");
	chk_mode_hold: assert property (!core_reset [*4] |-> $stable(mode))
		else $error("mode changed while running");
	chk_clear_read: assert property (s_arvalid && s_arready
		&& s_araddr == rstwd_pkg::WATCHDOG_CLEAR_ADDR
		|=> s_rvalid && s_rdata[7:0] == ROM_CLEAR_BYTE)
		else $error("clear location read wrong");
endmodule : rstwd_top_properties

bind rstwd_top rstwd_top_properties #(.STARTUP(STARTUP), .ROM_CLEAR_BYTE(ROM_CLEAR_BYTE)) chk_u (
	.aclk, .aresetn, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .stop_option, .cpu,
	.core_reset, .mode, .stop_active, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rvalid);

// ### dv/rstwd_ext_reset.sv
// External reset circuitry sharing the open-drain reset pin, with pull-up.
// Assumes the device drives only low, enabled by its oe.
`timescale 1ns/100ps
module rstwd_ext_reset #(
	parameter int RISE = 2
) (
	input  wire logic aclk,
	input  wire logic hold_low,
	input  wire logic dev_oe,
	input  wire logic dev_out,
	output logic      pin
);
	int slow;
	// slow rc rise after release, so the pin lags the last pull
	always_ff @(posedge aclk) begin
		if (hold_low || (dev_oe && !dev_out))
			slow <= RISE;
		else if (slow > 0)
			slow <= slow - 1;
	end
	// wired-and: either party pulls low, pull-up otherwise
	assign pin = !(hold_low || (dev_oe && !dev_out)) && slow == 0;
endmodule : rstwd_ext_reset

// ### dv/tb_reset_and_watchdog_control.sv
// Self-checking bench for the reset and watchdog block.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/100ps
module tb_reset_and_watchdog_control;
	localparam int         ST = 16;
	localparam int         WP = 64;
	localparam logic [7:0] RB = 8'h5A;
	logic aclk, aresetn, ext_low, irq_test_level, selfcheck_strap, wd_option, stop_option;
	logic pin, reset_pin_out, reset_pin_oe, core_reset, stop_active;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic [15:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, d;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp, r;
	rstwd_pkg::rstwd_cpu_s  cpu;
	rstwd_pkg::rstwd_mode_e mode;
	int err_count, checks_done, seed, n, k;
	logic [15:0] fa[8] = '{16'h007F, 16'h0080, 16'h01FF, 16'h0200,
		16'h0EFF, 16'h0F00, 16'h1FFF, 16'h2000};
	logic [15:0] rq[$];

	rstwd_top #(.WD_PERIOD(WP), .STARTUP(ST), .ROM_CLEAR_BYTE(RB)) dut_u (.aclk, .aresetn,
		.reset_pin_in(pin), .reset_pin_out, .reset_pin_oe, .irq_test_level, .selfcheck_strap,
		.wd_option, .stop_option, .cpu, .core_reset, .mode, .stop_active, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	rstwd_ext_reset ext_u (.aclk, .hold_low(ext_low), .dev_oe(reset_pin_oe),
		.dev_out(reset_pin_out), .pin);

	// ----------------------------------------
	// model, checks and bus tasks
	// ----------------------------------------
	// expected {resp, data} of a register read
	function automatic logic [33:0] exp_rd(input logic [15:0] a);
		if (a == rstwd_pkg::WATCHDOG_CLEAR_ADDR) return {rstwd_pkg::RESP_OKAY, 24'h0, RB};
		if (a == rstwd_pkg::CTRL_ADDR) return {rstwd_pkg::RESP_OKAY, 30'h0, rstwd_pkg::CTRL_RESET};
		return {rstwd_pkg::RESP_SLVERR, 32'h0};
	endfunction : exp_rd
	function automatic logic legal(input logic [15:0] a);
		return (a >= 16'h0080 && a <= 16'h01FF) || (a >= 16'h0F00 && a <= 16'h1FFF);
	endfunction : legal
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string m);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t %s: saw %h want %h", $time, m, seen, exp);
		end
	endtask : chk
	// both channels offered together; each released when taken
	task automatic axi_wr(input logic [15:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 0;
		w = 0;
		n = 0;
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (!aw && s_awready) begin aw = 1; s_awvalid <= 0; end
			if (!w && s_wready) begin w = 1; s_wvalid <= 0; end
		end while (!(aw && w && s_bvalid) && n < 50);
		s_bready <= 0;
		chk(s_bresp, rstwd_pkg::RESP_OKAY, "bresp");
	endtask : axi_wr
	task automatic axi_rd(input logic [15:0] a);
		logic ar;
		@(posedge aclk); // idle edge: rready is never driven twice in one step
		ar = 0;
		n = 0;
		s_araddr <= a;
		s_arvalid <= 1;
		s_rready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (!ar && s_arready) begin ar = 1; s_arvalid <= 0; end
		end while (!(ar && s_rvalid) && n < 50);
		s_rready <= 0;
		d = s_rdata;
		r = s_rresp;
	endtask : axi_rd
	// wait for core_reset to reach v, counting cycles and pulldown cycles
	task automatic wait_rst(input logic v, input int lim);
		n = 0;
		k = 0;
		while (core_reset !== v && n < lim) begin
			@(posedge aclk);
			n++;
			if (reset_pin_oe === 1'b1) k++;
		end
	endtask : wait_rst
	task automatic pulse_fetch(input logic [15:0] a);
		cpu.fetch <= 1;
		cpu.fetch_addr <= a;
		@(posedge aclk);
		cpu.fetch <= 0;
	endtask : pulse_fetch
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	// cut a hang short well past the expected run
	initial begin
		#(40 * 30000);
		err_count++;
		final_report();
	end
	initial begin
		{aresetn, ext_low, irq_test_level, selfcheck_strap, s_awvalid, s_wvalid} = '0;
		{s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
		{wd_option, stop_option, s_wstrb, seed, cpu} = {2'b11, 4'hF, 32'd58695, 20'h0};
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		wait_rst(0, ST + 60);
		chk(n >= ST, 1, "startup");
		chk(mode, rstwd_pkg::RSTWD_MODE_SINGLE, "mode");
		$display("test powerup done");
		rq = '{rstwd_pkg::CTRL_ADDR, rstwd_pkg::WATCHDOG_CLEAR_ADDR, 16'h0100};
		while (rq.size() > 0) begin
			axi_rd(rq[0]);
			chk({r, d}, exp_rd(rq.pop_front()), "read");
		end
		$display("test registers done");
		cpu.wait_mode <= 1;
		for (int i = 0; i < 8; i++) begin
			repeat (20 + ($random(seed) & 15)) @(posedge aclk);
			pulse_fetch(rstwd_pkg::ROM_LO + 16'($random(seed) & 16'h0FF));
			axi_wr(rstwd_pkg::WATCHDOG_CLEAR_ADDR, 32'h0);
			chk(core_reset, 0, "cleared watchdog");
		end
		{irq_test_level, selfcheck_strap} <= 2'b11;
		wait_rst(1, WP + 20);
		chk(n > WP - 8 && n < WP + 12, 1, "timeout");
		wait_rst(0, 60);
		@(posedge aclk);
		chk(mode, rstwd_pkg::RSTWD_MODE_CHECK, "mode after timeout");
		wait_rst(1, WP * 3);
		chk(core_reset, 0, "watchdog in self-check");
		$display("test watchdog done");
		{irq_test_level, selfcheck_strap} <= 2'b00;
		foreach (fa[i]) begin
			pulse_fetch(fa[i]);
			wait_rst(1, 6);
			chk(core_reset, !legal(fa[i]), "fetch");
			wait_rst(0, 60);
			@(posedge aclk);
			chk(mode, rstwd_pkg::RSTWD_MODE_CHECK, "mode kept");
			chk(k >= 4 || legal(fa[i]), 1, "pulldown");
		end
		$display("test fetch done");
		ext_low <= 1;
		wait_rst(1, 8);
		wait_rst(0, 12);
		chk(k, 4, "pin pulldown");
		chk(core_reset, 1, "pin reset");
		ext_low <= 0;
		wait_rst(0, 60);
		@(posedge aclk);
		chk(mode, rstwd_pkg::RSTWD_MODE_SINGLE, "mode after pin");
		$display("test pin done");
		stop_option <= 0;
		cpu.stop_exec <= 1;
		@(posedge aclk);
		cpu.stop_exec <= 0;
		wait_rst(1, 8);
		chk(core_reset, 1, "disabled stop");
		wait_rst(0, 60);
		stop_option <= 1;
		cpu.stop_exec <= 1;
		@(posedge aclk);
		cpu.stop_exec <= 0;
		repeat (4) @(posedge aclk);
		chk(stop_active, 1, "stop");
		wait_rst(1, WP * 3);
		chk(core_reset, 0, "stopped watchdog");
		cpu.stop_wake_irq <= 1;
		@(posedge aclk);
		cpu.stop_wake_irq <= 0;
		wait_rst(1, WP + 20);
		chk(n > WP - 10 && n < WP + 10, 1, "wake count");
		$display("test stop done");
		final_report();
	end
endmodule : tb_reset_and_watchdog_control
